// ### inc/bbar_consts.svh
// Address windows, field positions and encodings of the bit alias remapper
`ifndef BBAR_CONSTS_SVH
`define BBAR_CONSTS_SVH

// Top seven address bits that mark each 32 MB alias window
`define BBAR_TAG_SRAM_ALIAS 7'h11
`define BBAR_TAG_PERI_ALIAS 7'h21
// Top twelve address bits of each 1 MB bit-addressable region
`define BBAR_REGION_SRAM 12'h200
`define BBAR_REGION_PERI 12'h400
// Alias address fields: window tag, region byte offset, bit number
`define BBAR_TAG_HI 31
`define BBAR_TAG_LO 25
`define BBAR_OFS_HI 24
`define BBAR_OFS_LO 5
`define BBAR_BITN_HI 4
`define BBAR_BITN_LO 2
// Access size codes
`define BBAR_SZ_BYTE 2'h0
`define BBAR_SZ_HALF 2'h1
`define BBAR_SZ_WORD 2'h2
// Alias read answers
`define BBAR_BIT_SET 32'h0000_0001
`define BBAR_BIT_CLR 32'h0000_0000
// One-hot state codes
`define BBAR_ST_IDLE 4'h1
`define BBAR_ST_ISSUE 4'h2
`define BBAR_ST_WAIT 4'h4
`define BBAR_ST_RESP 4'h8

`endif

// ### inc/bbar_pkg.sv
// Types and helper functions of the bit alias remapper
`default_nettype none
`include "bbar_consts.svh"
package bbar_pkg;

  typedef enum logic [3:0] {
    BBAR_IDLE = `BBAR_ST_IDLE,
    BBAR_ISSUE = `BBAR_ST_ISSUE,
    BBAR_WAIT = `BBAR_ST_WAIT,
    BBAR_RESP = `BBAR_ST_RESP
  } bbar_state_t;

  // Underlying address aligned to the access size
  function automatic logic [31:0] bbar_align(input logic [31:0] a, input logic [1:0] sz);
    if (sz == `BBAR_SZ_WORD)
    begin
      return {a[31:2], 2'h0};
    end
    else if (sz == `BBAR_SZ_HALF)
    begin
      return {a[31:1], 1'h0};
    end
    return a;
  endfunction

  // Little-endian lane: byte n of a word sits in bits 8n+7..8n
  function automatic logic [4:0] bbar_lane_pos(input logic [1:0] byte_lo, input logic [2:0] bit_num);
    return {byte_lo, bit_num};
  endfunction

  // Replace one bit of a word, leaving all others as read
  function automatic logic [31:0] bbar_put_bit(input logic [31:0] w, input logic [4:0] pos, input logic v);
    logic [31:0] m;
    m = `BBAR_BIT_SET << pos;
    return v ? (w | m) : (w & ~m);
  endfunction

endpackage
`default_nettype wire

// ### core/bbar_remap.sv
// Address decoder that maps an alias word address onto a target bit
`default_nettype none
`include "bbar_consts.svh"
module bbar_remap
  import bbar_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic fetch,
  output logic in_alias,
  output logic refuse,
  output logic [31:0] bit_addr,
  output logic [2:0] bit_num
);

  logic win_sram;
  logic win_peri;
  logic [11:0] region_hi;

  assign win_sram = (addr[`BBAR_TAG_HI:`BBAR_TAG_LO] == `BBAR_TAG_SRAM_ALIAS);
  assign win_peri = (addr[`BBAR_TAG_HI:`BBAR_TAG_LO] == `BBAR_TAG_PERI_ALIAS);
  assign in_alias = (win_sram | win_peri) & ~fetch;
  assign refuse = win_peri & fetch;
  assign region_hi = win_peri ? `BBAR_REGION_PERI : `BBAR_REGION_SRAM;
  // window base dropped, region base put in its place
  assign bit_addr = {region_hi, addr[`BBAR_OFS_HI:`BBAR_OFS_LO]};
  assign bit_num = addr[`BBAR_BITN_HI:`BBAR_BITN_LO];

endmodule // bbar_remap
`default_nettype wire

// ### core/bbar_bridge.sv
// Bit alias remapping bridge between the processor data bus and its targets
`default_nettype none
`include "bbar_consts.svh"
module bbar_bridge
  import bbar_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cpu_req_valid,
  output logic cpu_req_ready,
  input wire logic [31:0] cpu_req_addr,
  input wire logic cpu_req_write,
  input wire logic cpu_req_fetch,
  input wire logic [1:0] cpu_req_size,
  input wire logic [31:0] cpu_req_wdata,
  output logic cpu_rsp_valid,
  output logic [31:0] cpu_rsp_rdata,
  output logic cpu_rsp_err,
  output logic tgt_valid,
  input wire logic tgt_ready,
  output logic [31:0] tgt_addr,
  output logic tgt_write,
  output logic [1:0] tgt_size,
  output logic [31:0] tgt_wdata,
  output logic tgt_lock,
  input wire logic tgt_rvalid,
  input wire logic [31:0] tgt_rdata,
  input wire logic tgt_rerr
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_r;
  logic rst_n_s;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_s <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_s <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the incoming request
  logic d_alias;
  logic d_refuse;
  logic [31:0] d_bit_addr;
  logic [2:0] d_bit_num;

  bbar_remap u_remap (
    .addr(cpu_req_addr),
    .fetch(cpu_req_fetch),
    .in_alias(d_alias),
    .refuse(d_refuse),
    .bit_addr(d_bit_addr),
    .bit_num(d_bit_num)
  );

  bbar_state_t state_r;
  logic ready_r;
  logic rsp_valid_r;
  logic [31:0] rsp_rdata_r;
  logic rsp_err_r;
  logic tv_r;
  logic [31:0] ta_r;
  logic tw_r;
  logic [1:0] ts_r;
  logic [31:0] td_r;
  logic tl_r;
  logic alias_r;
  logic wr_q_r;
  logic wbit_r;
  logic phase_r;
  logic [4:0] pos_r;
  logic [31:0] addr_q_r;
  logic [1:0] size_q_r;

  wire acc = cpu_req_valid & ready_r;
  // alias data goes to the region; size kept
  wire [31:0] d_tgt_addr = d_alias ? bbar_align(d_bit_addr, cpu_req_size) : cpu_req_addr;
  // bit lane in the word; byte lane little-endian
  wire [4:0] d_pos = bbar_lane_pos(d_bit_addr[1:0], d_bit_num);
  // only an alias write takes the locked RMW path
  wire rmw_turn = alias_r & wr_q_r & ~phase_r & ~tgt_rerr;
  // only bit 0 of the written value counts
  wire [31:0] rmw_data = bbar_put_bit(tgt_rdata, pos_r, wbit_r);
  // alias reads answer 0 or 1
  wire [31:0] bit_answer = tgt_rdata[pos_r] ? `BBAR_BIT_SET : `BBAR_BIT_CLR;
  wire [31:0] rsp_data = alias_r ? (wr_q_r ? `BBAR_BIT_CLR : bit_answer) : tgt_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer, one outstanding access at a time
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      state_r <= BBAR_IDLE;
      ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= `BBAR_BIT_CLR;
      rsp_err_r <= 1'b0;
      tv_r <= 1'b0;
      ta_r <= `BBAR_BIT_CLR;
      tw_r <= 1'b0;
      ts_r <= `BBAR_SZ_BYTE;
      td_r <= `BBAR_BIT_CLR;
      tl_r <= 1'b0;
      alias_r <= 1'b0;
      wr_q_r <= 1'b0;
      wbit_r <= 1'b0;
      phase_r <= 1'b0;
      pos_r <= 5'h0;
      addr_q_r <= `BBAR_BIT_CLR;
      size_q_r <= `BBAR_SZ_BYTE;
    end
    else
    begin
      case (state_r)
        BBAR_IDLE:
        begin
          ready_r <= ~acc;
          if (acc)
          begin
            addr_q_r <= cpu_req_addr;
            size_q_r <= cpu_req_size;
            alias_r <= d_alias;
            wr_q_r <= cpu_req_write;
            wbit_r <= cpu_req_wdata[0];
            phase_r <= 1'b0;
            pos_r <= d_pos;
            ta_r <= d_tgt_addr;
            ts_r <= cpu_req_size;
            // an alias write starts with its read half
            tw_r <= cpu_req_write & ~d_alias;
            td_r <= cpu_req_wdata;
            // lock the target for the whole RMW
            tl_r <= d_alias & cpu_req_write;
            if (d_refuse)
            begin
              // answer with an error, target untouched
              state_r <= BBAR_RESP;
              rsp_valid_r <= 1'b1;
              rsp_err_r <= 1'b1;
              rsp_rdata_r <= `BBAR_BIT_CLR;
            end
            else
            begin
              state_r <= BBAR_ISSUE;
              tv_r <= 1'b1;
            end
          end
        end
        BBAR_ISSUE:
        begin
          if (tgt_ready)
          begin
            tv_r <= 1'b0;
            state_r <= BBAR_WAIT;
          end
        end
        BBAR_WAIT:
        begin
          if (tgt_rvalid && rmw_turn)
          begin
            // write half issued right after the read half
            phase_r <= 1'b1;
            tw_r <= 1'b1;
            td_r <= rmw_data;
            tv_r <= 1'b1;
            state_r <= BBAR_ISSUE;
          end
          else if (tgt_rvalid)
          begin
            rsp_valid_r <= 1'b1;
            rsp_err_r <= tgt_rerr;
            rsp_rdata_r <= rsp_data;
            tl_r <= 1'b0;
            state_r <= BBAR_RESP;
          end
        end
        BBAR_RESP:
        begin
          rsp_valid_r <= 1'b0;
          rsp_err_r <= 1'b0;
          ready_r <= 1'b1;
          state_r <= BBAR_IDLE;
        end
        default:
        begin
          state_r <= BBAR_IDLE;
        end
      endcase
    end
  end

  assign cpu_req_ready = ready_r;
  assign cpu_rsp_valid = rsp_valid_r;
  assign cpu_rsp_rdata = rsp_rdata_r;
  assign cpu_rsp_err = rsp_err_r;
  assign tgt_valid = tv_r;
  assign tgt_addr = ta_r;
  assign tgt_write = tw_r;
  assign tgt_size = ts_r;
  assign tgt_wdata = td_r;
  assign tgt_lock = tl_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_s);

  logic [31:0] rmw_rd_r;
  always_ff @(posedge mclk)
  begin
    if (state_r == BBAR_WAIT && tgt_rvalid)
    begin
      rmw_rd_r <= tgt_rdata;
    end
  end

  AST_PASS_ADDR: assert property (
    tv_r && !alias_r |-> ta_r == addr_q_r && ts_r == size_q_r)
    else $error("pass-through access altered");
  AST_REMAP_ADDR: assert property (
    tv_r && alias_r |-> ta_r[31:20] == (addr_q_r[30] ? `BBAR_REGION_PERI : `BBAR_REGION_SRAM)
      && ta_r[19:2] == addr_q_r[24:7])
    else $error("alias access sent to wrong region word");
  AST_BYTE_OFFSET: assert property (
    tv_r && alias_r && size_q_r == `BBAR_SZ_BYTE |-> {ta_r[19:0], pos_r[2:0], 2'h0} == addr_q_r[24:0])
    else $error("alias offset does not match byte and bit");
  AST_SIZE_KEPT: assert property (
    tv_r |-> ts_r == size_q_r)
    else $error("access size changed");
  AST_SRAM_FETCH: assert property (
    acc && cpu_req_fetch && cpu_req_addr[31:25] == `BBAR_TAG_SRAM_ALIAS
      |=> tv_r && !alias_r && ta_r == $past(cpu_req_addr))
    else $error("SRAM alias fetch was remapped");
  AST_PERI_FETCH: assert property (
    acc && cpu_req_fetch && cpu_req_addr[31:25] == `BBAR_TAG_PERI_ALIAS
      |=> rsp_valid_r && rsp_err_r && !tv_r ##1 !tv_r)
    else $error("peripheral alias fetch not refused");
  AST_RMW_READ_FIRST: assert property (
    $rose(tl_r) |-> tv_r && !tw_r)
    else $error("alias write did not start with a read");
  AST_RMW_BIT: assert property (
    tv_r && tw_r && alias_r |-> td_r == bbar_put_bit(rmw_rd_r, pos_r, wbit_r))
    else $error("alias write changed more than the target bit");
  AST_RMW_BACK: assert property (
    state_r == BBAR_WAIT && tgt_rvalid && rmw_turn |=> tv_r && tw_r && tl_r)
    else $error("RMW write half not issued back to back");
  AST_READ_VALUE: assert property (
    rsp_valid_r && alias_r && !rsp_err_r |-> rsp_rdata_r[31:1] == 31'h0)
    else $error("alias read returned more than one bit");

endmodule // bbar_bridge
`default_nettype wire

// ### tb/bbar_tgt_model.sv
// Behavioural memory target that answers the bridge, promptly or slowly
`default_nettype none
module bbar_tgt_model
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic tgt_valid,
  output logic tgt_ready,
  input wire logic [31:0] tgt_addr,
  input wire logic tgt_write,
  input wire logic [1:0] tgt_size,
  input wire logic [31:0] tgt_wdata,
  input wire logic tgt_lock,
  output logic tgt_rvalid,
  output logic [31:0] tgt_rdata,
  output logic tgt_rerr,
  input wire logic slow,
  input wire logic [31:0] err_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [bit [31:0]];
  logic pend, w;
  logic [31:0] a, wd, aw;
  logic [1:0] sz;
  logic [3:0] ph;
  // Unwritten bytes hold an address pattern so stale reads show up
  function automatic logic [7:0] rd8(input logic [31:0] x);
    return mem.exists(x) ? mem[x] : x[7:0] ^ 8'h5a;
  endfunction
  assign aw = {a[31:2], 2'h0};
  // Signals change off the sampling edge; released data toggles every cycle
  always @(posedge mclk or negedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {tgt_ready, tgt_rvalid, tgt_rerr, pend} <= 4'h0;
      tgt_rdata <= 32'h0;
      ph <= 4'h0;
    end
    else if (mclk)
    begin
      if (tgt_valid && tgt_ready && !pend)
      begin
        {pend, a, w, sz, wd} <= {1'b1, tgt_addr, tgt_write, tgt_size, tgt_wdata};
      end
    end
    else
    begin
      ph <= ph + 4'h1;
      {tgt_rvalid, tgt_rerr} <= 2'h0;
      tgt_rdata <= ~tgt_rdata;
      tgt_ready <= !slow || ph[0];
      if (pend && (!slow || ph[1]))
      begin
        pend <= 1'b0;
        tgt_rvalid <= 1'b1;
        tgt_rerr <= (a === err_addr);
        if (w)
        begin
          for (int k = 0; k < 4; k++)
            if (sz == 2'h2 || (sz == 2'h1 && k[1] == a[1]) || k[1:0] == a[1:0])
              mem[aw + k] = wd[8 * k +: 8];
        end
        else
          tgt_rdata <= {rd8(aw + 3), rd8(aw + 2), rd8(aw + 1), rd8(aw)};
      end
    end
  end
endmodule // bbar_tgt_model
`default_nettype wire

// ### tb/bbar_bridge_tb_top.sv
// Self-checking bench of the bit alias bridge against a byte-level model
`default_nettype none
module bbar_bridge_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset_n, cpu_req_valid, cpu_req_ready, cpu_req_write, cpu_req_fetch, cpu_rsp_valid, cpu_rsp_err;
  logic tgt_valid, tgt_ready, tgt_write, tgt_lock, tgt_rvalid, tgt_rerr, slow;
  logic [1:0] cpu_req_size, tgt_size, last_size;
  logic [31:0] cpu_req_addr, cpu_req_wdata, cpu_rsp_rdata, tgt_addr, tgt_wdata, tgt_rdata, err_addr;
  logic [7:0] ref_mem [bit [31:0]];
  int error_cnt, samples_checked, acc_cnt, lock_cnt;
  bit [31:0] seed = 5;
  bbar_bridge i_bbar_bridge (.mclk, .reset_n, .cpu_req_valid, .cpu_req_ready, .cpu_req_addr, .cpu_req_write,
    .cpu_req_fetch, .cpu_req_size, .cpu_req_wdata, .cpu_rsp_valid, .cpu_rsp_rdata, .cpu_rsp_err, .tgt_valid,
    .tgt_ready, .tgt_addr, .tgt_write, .tgt_size, .tgt_wdata, .tgt_lock, .tgt_rvalid, .tgt_rdata, .tgt_rerr);
  bbar_tgt_model i_bbar_tgt_model (.mclk, .reset_n, .tgt_valid, .tgt_ready, .tgt_addr, .tgt_write, .tgt_size,
    .tgt_wdata, .tgt_lock, .tgt_rvalid, .tgt_rdata, .tgt_rerr, .slow, .err_addr);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (tgt_valid && tgt_ready)
    begin
      acc_cnt++;
      last_size = tgt_size;
      if (tgt_lock)
        lock_cnt++;
    end
  function automatic logic [7:0] rb(input bit [31:0] x);
    return ref_mem.exists(x) ? ref_mem[x] : x[7:0] ^ 8'h5a;
  endfunction
  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One request through the bridge, checked against the byte model
  task automatic op(input bit [31:0] a, input bit w, input bit f, input bit [1:0] sz, input bit [31:0] wd);
    int n, acc0, lk0;
    bit al, er;
    bit [31:0] ba, ta;
    bit [2:0] b;
    acc0 = acc_cnt;
    lk0 = lock_cnt;
    al = (a[31:25] == 7'h11 || a[31:25] == 7'h21) && !f;
    ba = al ? {(a[30] ? 12'h400 : 12'h200), a[24:5]} : a;
    b = a[4:2];
    ta = sz == 2'h2 ? {ba[31:2], 2'h0} : sz == 2'h1 ? {ba[31:1], 1'h0} : ba;
    er = (f && a[31:25] == 7'h21) || ta == err_addr;
    @(negedge mclk);
    {cpu_req_valid, cpu_req_addr, cpu_req_write, cpu_req_fetch, cpu_req_size, cpu_req_wdata} = {1'b1, a, w, f, sz, wd};
    n = 0;
    // Ready is looked at between edges; the next rising edge takes the request
    while (cpu_req_ready !== 1'b1 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    @(negedge mclk);
    cpu_req_valid = 1'b0;
    // A refused fetch answers on the taking edge, so look before waiting
    while (cpu_rsp_valid !== 1'b1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    if (cpu_rsp_valid !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: no answer", $time);
      complete_run();
    end
    check(cpu_rsp_err, er, "error flag");
    if (f && a[31:25] == 7'h21)
      check(acc_cnt, acc0, "refused fetch reached target");
    else
      check(last_size, sz, "target size");
    if (!er && al && w)
    begin
      ref_mem[ba] = wd[0] ? rb(ba) | (8'h1 << b) : rb(ba) & ~(8'h1 << b);
      check(cpu_rsp_rdata, 32'h0, "alias write answer");
      check(lock_cnt - lk0, 2, "locked halves");
    end
    else if (!er && al)
      check(cpu_rsp_rdata, {31'h0, rb(ba) >> b & 8'h1}, "alias read");
    else if (!er && w)
    begin
      for (int k = 0; k < 4; k++)
        if (sz == 2'h2 || (sz == 2'h1 && k[1] == a[1]) || k[1:0] == a[1:0])
          ref_mem[{a[31:2], 2'h0} + k] = wd[8 * k +: 8];
    end
    else if (!er)
      check(cpu_rsp_rdata, {rb(ta | 3), rb(ta | 2), rb(ta | 1), rb(ta & ~3)}, "direct read");
  endtask
  initial
  begin
    {reset_n, cpu_req_valid, cpu_req_write, cpu_req_fetch, slow} = 5'h0;
    {cpu_req_size, cpu_req_addr, cpu_req_wdata} = 66'h0;
    err_addr = 32'hffff_fff0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    op(32'h2000_0100, 1, 0, 2'h2, 32'h4433_2211);
    op(32'h2000_0100, 0, 0, 2'h2, 0);
    // Bits of the second byte show the little-endian placement
    for (int i = 0; i < 8; i++)
      op(32'h2200_0000 + 32'h101 * 32 + i * 4, 0, 0, 2'h2, 0);
    for (int s = 0; s < 3; s++)
    begin
      op(32'h23ff_fffc, 1, 0, s[1:0], 32'hffff_fffe);
      op(32'h23ff_fffc, 0, 0, s[1:0], 0);
      op(32'h23ff_fffc, 1, 0, s[1:0], 32'h0000_0001);
      op(32'h23ff_fffc, 0, 0, s[1:0], 0);
    end
    op(32'h4000_0040, 1, 0, 2'h2, 32'h0000_00ff);
    op(32'h43ff_ffe0, 1, 0, 2'h2, 32'h0000_000e);
    op(32'h400f_fffc, 0, 0, 2'h2, 0);
    op(32'h4200_0000, 0, 1, 2'h2, 0);
    op(32'h2200_0004, 0, 1, 2'h2, 0);
    op(32'h6000_0010, 1, 0, 2'h1, 32'h1234_abcd);
    op(32'h6000_0010, 0, 0, 2'h2, 0);
    err_addr = 32'h2000_0000;
    op(32'h2200_0020, 1, 0, 2'h2, 32'h1);
    err_addr = 32'hffff_fff0;
    op(32'h2200_0020, 0, 0, 2'h2, 0);
    slow = 1'b1;
    for (int i = 0; i < 60; i++)
      op(xs() & 32'h1 ? 32'h2200_0000 | (xs() & 32'h3fc) : 32'h2000_0000 | (xs() & 32'h1c),
        xs() & 32'h1, 0, (xs() % 3), xs());
    complete_run();
  end
endmodule // bbar_bridge_tb_top
`default_nettype wire
